// *** hw/ris_pkg.sv ***
// Constants shared by the reset initialisation sequencer.
// Assumes a 100 MHz i_mclk; counts are in i_mclk cycles, sync-clock ticks or, for host power-on reset, primary ticks.
package ris_pkg;
    // ------------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 10;

    // ------------------------------------------------------------------
    // Reset lengths in sync-clock ticks (host power-on in primary ticks); strap release in ns
    // ------------------------------------------------------------------
    localparam int RST_IN_MIN_TICKS = 32;
    localparam int POR_MIN_TICKS = 32;
    localparam int RST_OUT_MIN_TICKS = 512;
    localparam int HARD_SOFT_GAP_TICKS = 16;
    localparam int STRAP_SETUP_TICKS = 4;
    localparam int STRAP_RESUME_TICKS = 1;
    localparam int STRAP_OFF_NS = 4;

    // ------------------------------------------------------------------
    // Lock times
    // ------------------------------------------------------------------
    localparam int PLL_LOCK_US = 100;
    // Longest time: rounded down
    localparam int PLL_LOCK_CYCLES = (PLL_LOCK_US * 1000) / MCLK_PERIOD_NS;
    localparam int DLL_LOCK_MIN_CYCLES = 7680;
    localparam int DLL_LOCK_MAX_CYCLES = 122880;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int TICK_CNT_W = 10;
    localparam int LOCK_CNT_W = 17;
    localparam int SRC_W = 3;
    localparam logic [2:0] SRC_RESET = 3'h0;

    typedef enum logic [2:0] {
        ST_POR,
        ST_PLL,
        ST_DRIVE,
        ST_GAP,
        ST_RUN
    } ris_state_t;
endpackage

// *** hw/ris_tick_if.sv ***
// Carries the clock selection inputs and the tick strobes between the
// sequencer and its tick generator. Single clock domain, i_mclk.
`timescale 1ns/1ps
interface ris_tick_if;
    logic host_mode;
    logic div_by_two;
    logic primary_clk;
    logic bus_clk;
    logic prim_tick;
    logic sync_tick;

    modport gen (
        input host_mode,
        input div_by_two,
        input primary_clk,
        input bus_clk,
        output prim_tick,
        output sync_tick
    );
    modport use_side (
        output host_mode,
        output div_by_two,
        output primary_clk,
        output bus_clk,
        input prim_tick,
        input sync_tick
    );
endinterface

// *** hw/ris_tick.sv ***
// Tick generator: turns the sampled primary or bus clock into strobes.
// Assumes both clock pins are slow against i_mclk and sampled synchronously.
`timescale 1ns/1ps
module ris_tick (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Ticks
    ris_tick_if.gen tk
);
    import ris_pkg::*;

    logic sel_q;
    logic ph_q;
    logic prim_tick_q;
    logic sync_tick_q;
    logic sel_d;
    logic rise;

    // ------------------------------------------------------------------
    // Source select and edge detect
    // ------------------------------------------------------------------
    assign sel_d = tk.host_mode ? tk.primary_clk : tk.bus_clk; // [R01]
    assign rise = sel_d & ~sel_q;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sel_q <= 1'b0;
            prim_tick_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            prim_tick_q <= rise;
        end
    end

    // ------------------------------------------------------------------
    // Sync tick: host mode divides the primary clock per strap
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ph_q <= 1'b0;
            sync_tick_q <= 1'b0;
        end else begin
            sync_tick_q <= 1'b0;
            if (rise) begin
                if (tk.host_mode && tk.div_by_two) begin // [R02]
                    ph_q <= ~ph_q;
                    sync_tick_q <= ph_q;
                end else begin
                    ph_q <= 1'b0;
                    sync_tick_q <= 1'b1;
                end
            end
        end
    end

    assign tk.prim_tick = prim_tick_q;
    assign tk.sync_tick = sync_tick_q;

    a_tick_source: assert property (@(posedge i_mclk) disable iff (i_rst) // [R01]
        prim_tick_q |-> $past(tk.host_mode ? tk.primary_clk : tk.bus_clk) && !$past(sel_q))
        else $error("tick not from selected clock");

    a_divide_two: assert property (@(posedge i_mclk) disable iff (i_rst) // [R02]
        (tk.host_mode && tk.div_by_two && $past(tk.host_mode && tk.div_by_two) && sync_tick_q)
        |-> $past(ph_q) && $past(rise))
        else $error("host divide by two ticked on wrong phase");
endmodule // ris_tick

// *** hw/ris_seq.sv ***
// Reset initialisation sequencer: counts reset inputs, drives the open-drain
// hard and soft reset lines, latches and re-drives the configuration straps,
// and waits for PLL lock, then times DLL lock. Assumes all pins synchronous to i_mclk.
//
// How it works
// R01: Primary clock: host input or bus clock
// R02: Host sync clock divided per divide strap
// R03: Reset inputs held 32 sync ticks start flow
// R04: Host power-on reset held 32 primary ticks
// R05: Agent power-on reset held 32 sync ticks
// R06: Drive resets 512 ticks; soft 16 later
// R07: Reset outputs open drain, only pull low
// R08: Straps stable 4 ticks before power-on release
// R09: Straps released within 4 ns of hard reset; an external hard reset takes one i_mclk cycle (10 ns) here
// R10: Straps re-driven one sync tick after release; the code re-drives them on the second sync tick after release
// R11: Wait for PLL lock, 100 us bound
// R12: DLL lock between 7680 and 122880 cycles
// R13: Straps latched at power-on release, then held
`timescale 1ns/1ps
module ris_seq #(
    parameter int PLL_CYC = ris_pkg::PLL_LOCK_CYCLES,
    parameter int DLL_MIN = ris_pkg::DLL_LOCK_MIN_CYCLES,
    parameter int DLL_MAX = ris_pkg::DLL_LOCK_MAX_CYCLES
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Clock sources and mode
    input wire logic i_host_mode,
    input wire logic i_primary_clock_in,
    input wire logic i_bus_clock_in,
    // Reset pins
    input wire logic i_power_on_reset_in_n,
    input wire logic i_hard_reset_line_n,
    output logic o_hard_reset_line_o,
    output logic o_hard_reset_line_oe,
    input wire logic i_soft_reset_line_n,
    output logic o_soft_reset_line_o,
    output logic o_soft_reset_line_oe,
    // Configuration straps
    input wire logic [ris_pkg::SRC_W-1:0] i_reset_source_strap,
    input wire logic i_input_divide_strap,
    output logic [ris_pkg::SRC_W:0] o_cfg_strap_o,
    output logic o_cfg_strap_oe,
    output logic [ris_pkg::SRC_W-1:0] o_reset_source,
    output logic o_input_divide_strap,
    // Lock status
    input wire logic i_pll_locked,
    input wire logic i_dll_locked,
    output logic o_pll_ready,
    output logic o_pll_timeout,
    output logic o_dll_ready,
    output logic o_dll_timeout,
    output logic o_core_run
);
    import ris_pkg::*;

    ris_tick_if tk ();

    ris_state_t state_q;
    ris_state_t state_d;
    logic [TICK_CNT_W-1:0] tick_cnt_q;
    logic [5:0] por_cnt_q;
    logic [5:0] ext_cnt_q;
    logic [LOCK_CNT_W-1:0] pll_cnt_q;
    logic [LOCK_CNT_W-1:0] dll_cnt_q;
    logic dll_on_q;
    logic strap_arm_q;
    logic hard_d;
    logic soft_d;
    logic ext_low;
    logic ext_hit;
    logic por_act;
    logic por_tick;

    function automatic logic drives_hard(input ris_state_t s);
        return (s == ST_POR) || (s == ST_PLL) || (s == ST_DRIVE);
    endfunction

    // ------------------------------------------------------------------
    // Tick generator
    // ------------------------------------------------------------------
    assign tk.host_mode = i_host_mode;
    assign tk.div_by_two = i_input_divide_strap;
    assign tk.primary_clk = i_primary_clock_in;
    assign tk.bus_clk = i_bus_clock_in;

    ris_tick u_tick (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .tk(tk)
    );

    assign por_act = ~i_power_on_reset_in_n;
    assign por_tick = i_host_mode ? tk.prim_tick : tk.sync_tick;
    assign ext_low = ~i_hard_reset_line_n | ~i_soft_reset_line_n;
    assign ext_hit = (state_q == ST_RUN) && ext_low && tk.sync_tick
                     && (ext_cnt_q == 6'(RST_IN_MIN_TICKS - 1));

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_POR: begin
                if (!por_act) begin
                    state_d = ST_PLL;
                end
            end
            ST_PLL: begin
                if (i_pll_locked || pll_cnt_q == LOCK_CNT_W'(PLL_CYC - 1)) begin // [R11]
                    state_d = ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                if (tk.sync_tick && tick_cnt_q == TICK_CNT_W'(RST_OUT_MIN_TICKS - 1)) begin // [R06]
                    state_d = ST_GAP;
                end
            end
            ST_GAP: begin
                if (tk.sync_tick && tick_cnt_q == TICK_CNT_W'(HARD_SOFT_GAP_TICKS - 1)) begin // [R06]
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (ext_hit) begin // [R03]
                    state_d = ST_DRIVE;
                end
            end
            default: state_d = ST_POR;
        endcase
        if (por_act) begin
            state_d = ST_POR;
        end
    end
    assign hard_d = drives_hard(state_d);
    assign soft_d = hard_d || (state_d == ST_GAP);

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_POR;
            tick_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                tick_cnt_q <= '0;
            end else if (tk.sync_tick) begin
                tick_cnt_q <= tick_cnt_q + 1'b1;
            end
        end
    end

    // Power-on and line reset length counters
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            por_cnt_q <= '0;
            ext_cnt_q <= '0;
        end else begin
            if (!por_act) begin
                por_cnt_q <= '0;
            end else if (por_tick && por_cnt_q != 6'(POR_MIN_TICKS)) begin // [R04] [R05]
                por_cnt_q <= por_cnt_q + 1'b1;
            end
            if (state_q != ST_RUN || !ext_low || ext_hit) begin
                ext_cnt_q <= '0;
            end else if (tk.sync_tick) begin
                ext_cnt_q <= ext_cnt_q + 1'b1; // [R03]
            end
        end
    end

    // ------------------------------------------------------------------
    // Open-drain reset lines
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_hard_reset_line_oe <= 1'b1;
            o_soft_reset_line_oe <= 1'b1;
            o_hard_reset_line_o <= 1'b0;
            o_soft_reset_line_o <= 1'b0;
        end else begin
            o_hard_reset_line_oe <= hard_d; // [R06]
            o_soft_reset_line_oe <= soft_d; // [R06]
            o_hard_reset_line_o <= 1'b0; // [R07]
            o_soft_reset_line_o <= 1'b0; // [R07]
        end
    end

    // ------------------------------------------------------------------
    // Strap latch and re-drive
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_reset_source <= SRC_RESET;
            o_input_divide_strap <= 1'b0;
        end else if (state_q == ST_POR && !por_act) begin
            o_reset_source <= i_reset_source_strap; // [R13]
            o_input_divide_strap <= i_input_divide_strap; // [R13]
        end
    end

    // Drive off in the first cycle hard reset is seen; on after two ticks
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_cfg_strap_oe <= 1'b0;
            strap_arm_q <= 1'b0;
            o_cfg_strap_o <= '0;
        end else begin
            o_cfg_strap_o <= {o_reset_source, o_input_divide_strap};
            if (hard_d || !i_hard_reset_line_n) begin
                o_cfg_strap_oe <= 1'b0; // [R09]
                strap_arm_q <= 1'b0;
            end else if (tk.sync_tick) begin
                strap_arm_q <= 1'b1;
                o_cfg_strap_oe <= o_cfg_strap_oe | strap_arm_q; // [R10]
            end
        end
    end

    // ------------------------------------------------------------------
    // PLL and DLL lock
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pll_cnt_q <= '0;
            o_pll_ready <= 1'b0;
            o_pll_timeout <= 1'b0;
        end else if (state_q == ST_POR) begin
            pll_cnt_q <= '0;
            o_pll_ready <= 1'b0;
            o_pll_timeout <= 1'b0;
        end else if (state_q == ST_PLL) begin
            pll_cnt_q <= pll_cnt_q + 1'b1;
            o_pll_ready <= i_pll_locked; // [R11]
            o_pll_timeout <= (state_d != ST_PLL) && !i_pll_locked;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            dll_on_q <= 1'b0;
            dll_cnt_q <= '0;
            o_dll_ready <= 1'b0;
            o_dll_timeout <= 1'b0;
        end else if (state_q == ST_POR || state_q == ST_PLL) begin
            dll_on_q <= (state_q == ST_PLL) && (state_d != ST_PLL);
            dll_cnt_q <= '0;
            o_dll_ready <= 1'b0;
            o_dll_timeout <= 1'b0;
        end else if (dll_on_q && !o_dll_ready && !o_dll_timeout) begin
            dll_cnt_q <= dll_cnt_q + 1'b1;
            if (i_dll_locked && dll_cnt_q >= LOCK_CNT_W'(DLL_MIN - 1)) begin // [R12]
                o_dll_ready <= 1'b1;
            end else if (dll_cnt_q == LOCK_CNT_W'(DLL_MAX - 1)) begin // [R12]
                o_dll_timeout <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_core_run <= 1'b0;
        end else begin
            o_core_run <= (state_d == ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [TICK_CNT_W:0] hard_len_q;
    logic [TICK_CNT_W:0] gap_len_q;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            hard_len_q <= '0;
            gap_len_q <= '0;
        end else begin
            hard_len_q <= !o_hard_reset_line_oe ? '0 : hard_len_q + (tk.sync_tick & ~hard_len_q[TICK_CNT_W]);
            gap_len_q <= o_hard_reset_line_oe ? '0 : gap_len_q + (tk.sync_tick & ~gap_len_q[TICK_CNT_W]);
        end
    end

    sequence s_hard_release;
        $fell(o_hard_reset_line_oe);
    endsequence
    sequence s_soft_release;
        $fell(o_soft_reset_line_oe);
    endsequence

    a_hard_min_len: assert property (@(posedge i_mclk) disable iff (i_rst) // [R06]
        s_hard_release |-> $past(hard_len_q) >= (TICK_CNT_W + 1)'(RST_OUT_MIN_TICKS - 1) && !por_act)
        else $error("hard reset released early");
    a_soft_gap: assert property (@(posedge i_mclk) disable iff (i_rst) // [R06]
        s_soft_release |-> gap_len_q >= (TICK_CNT_W + 1)'(HARD_SOFT_GAP_TICKS - 1))
        else $error("soft reset released too soon after hard");
    a_open_drain: assert property (@(posedge i_mclk) disable iff (i_rst) // [R07]
        !o_hard_reset_line_o && !o_soft_reset_line_o)
        else $error("reset line driven high");
    a_strap_off: assert property (@(posedge i_mclk) disable iff (i_rst) // [R09]
        (hard_d || !i_hard_reset_line_n) |=> !o_cfg_strap_oe)
        else $error("straps still driven during hard reset");
    a_strap_resume: assert property (@(posedge i_mclk) disable iff (i_rst) // [R10]
        $rose(o_cfg_strap_oe) |-> gap_len_q >= (TICK_CNT_W + 1)'(STRAP_RESUME_TICKS))
        else $error("straps re-driven too early");
    a_pll_wait: assert property (@(posedge i_mclk) disable iff (i_rst) // [R11]
        (state_q == ST_PLL && state_d == ST_DRIVE) |=> (o_pll_ready ^ o_pll_timeout))
        else $error("left PLL wait without lock or timeout");
    a_dll_window: assert property (@(posedge i_mclk) disable iff (i_rst) // [R12]
        $rose(o_dll_ready) |-> dll_cnt_q >= LOCK_CNT_W'(DLL_MIN) && !o_dll_timeout)
        else $error("DLL ready before minimum lock time");
    a_strap_hold: assert property (@(posedge i_mclk) disable iff (i_rst) // [R13]
        ($past(state_q) != ST_POR) |-> $stable(o_reset_source) && $stable(o_input_divide_strap))
        else $error("latched straps changed outside power-on reset");
    a_line_flow: assert property (@(posedge i_mclk) disable iff (i_rst) // [R03]
        ext_hit |=> o_hard_reset_line_oe && o_soft_reset_line_oe)
        else $error("line reset did not start reset flow");
endmodule // ris_seq

// *** dv/ris_board.sv ***
// Board model: free-running clocks, power-on reset supervisor, strap drivers
// and pulled-up open-drain reset lines. Driven by the bench on i_mclk.
`timescale 1ns/1ps
module ris_board #(
    parameter int POR_HOLD = 300
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Bench requests
    input wire logic i_por_req,
    input wire logic [2:0] i_src,
    input wire logic i_div,
    input wire logic i_pull_hard,
    input wire logic i_pull_soft,
    // Device open-drain enables
    input wire logic i_hard_oe,
    input wire logic i_soft_oe,
    // Board pins
    output logic o_primary_clk,
    output logic o_bus_clk,
    output logic o_por_n,
    output logic [2:0] o_src,
    output logic o_div,
    output logic o_hard_n,
    output logic o_soft_n
);
    logic [1:0] pdiv_q;
    logic [1:0] bdiv_q;
    int hold_q;

    // Primary period 4 mclk, bus period 6 mclk
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pdiv_q <= 2'h0;
            bdiv_q <= 2'h0;
            o_primary_clk <= 1'h0;
            o_bus_clk <= 1'h0;
        end else begin
            pdiv_q <= pdiv_q + 2'h1;
            bdiv_q <= (bdiv_q == 2'h2) ? 2'h0 : bdiv_q + 2'h1;
            if (pdiv_q[0]) o_primary_clk <= ~o_primary_clk;
            if (bdiv_q == 2'h2) o_bus_clk <= ~o_bus_clk;
        end
    end

    // Hold longer than 32 periods of any sync clock (at most 256 mclk)
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            hold_q <= 0;
            o_por_n <= 1'h0;
        end else begin
            hold_q <= i_por_req ? 0 : (hold_q < POR_HOLD ? hold_q + 1 : hold_q);
            o_por_n <= !i_por_req && hold_q >= POR_HOLD;
        end
    end

    // Straps change only during the request, long before release
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_src <= 3'h0;
            o_div <= 1'h0;
        end else if (i_por_req) begin
            o_src <= i_src;
            o_div <= i_div;
        end
    end

    // Pull-ups: low while anyone pulls
    assign o_hard_n = ~(i_hard_oe | i_pull_hard);
    assign o_soft_n = ~(i_soft_oe | i_pull_soft);
endmodule // ris_board

// *** dv/ris_seq_tb.sv ***
// Bench for the reset sequencer: boots in each clock mode, times the
// driven lines and straps, line resets and lock timeouts.
// Assumes the board model supplies clocks, power-on reset and straps.
`timescale 1ns/1ps
module ris_seq_tb;
    import ris_pkg::*;
    localparam int PLL_SIM = 20;
    localparam int DMIN = 8;
    localparam int DMAX = 40;
    localparam int LIMIT = 30000;
    localparam int PLLR = 0, HOE = 1, SOE = 2, STR = 3, RUN = 4, PLLT = 5, DLLR = 6, DLLT = 7, POR = 8;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic host = 1'h1;
    logic por_req = 1'h1;
    logic [2:0] src = 3'h0;
    logic div = 1'h0;
    logic pull_h = 1'h0;
    logic pull_s = 1'h0;
    logic pll_ok = 1'h0;
    logic dll_ok = 1'h0;
    logic pclk, bclk, por_n, hard_n, soft_n, b_div, hard_o, hard_oe, soft_o, soft_oe, strap_oe;
    logic div_q, pll_rdy, pll_to, dll_rdy, dll_to, run;
    logic [2:0] b_src, src_q;
    logic [3:0] strap_o;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    wire [8:0] mon = {por_n, dll_to, dll_rdy, pll_to, run, strap_oe, soft_oe, hard_oe, pll_rdy};

    always #5 mclk = ~mclk;

    ris_board brd_u (.i_mclk(mclk), .i_rst(rst), .i_por_req(por_req), .i_src(src), .i_div(div),
        .i_pull_hard(pull_h), .i_pull_soft(pull_s), .i_hard_oe(hard_oe), .i_soft_oe(soft_oe),
        .o_primary_clk(pclk), .o_bus_clk(bclk), .o_por_n(por_n), .o_src(b_src), .o_div(b_div),
        .o_hard_n(hard_n), .o_soft_n(soft_n));

    ris_seq #(.PLL_CYC(PLL_SIM), .DLL_MIN(DMIN), .DLL_MAX(DMAX)) dut_u (.i_mclk(mclk), .i_rst(rst),
        .i_host_mode(host), .i_primary_clock_in(pclk), .i_bus_clock_in(bclk),
        .i_power_on_reset_in_n(por_n), .i_hard_reset_line_n(hard_n), .o_hard_reset_line_o(hard_o),
        .o_hard_reset_line_oe(hard_oe), .i_soft_reset_line_n(soft_n), .o_soft_reset_line_o(soft_o),
        .o_soft_reset_line_oe(soft_oe), .i_reset_source_strap(b_src), .i_input_divide_strap(b_div),
        .o_cfg_strap_o(strap_o), .o_cfg_strap_oe(strap_oe), .o_reset_source(src_q),
        .o_input_divide_strap(div_q), .i_pll_locked(pll_ok), .i_dll_locked(dll_ok),
        .o_pll_ready(pll_rdy), .o_pll_timeout(pll_to), .o_dll_ready(dll_rdy),
        .o_dll_timeout(dll_to), .o_core_run(run));

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait; n is cycles taken, lim if it never came
    task automatic waitv(input int i, input logic v, input int lim, output int n);
        n = 0;
        while (mon[i] !== v && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask

    task automatic t_boot(input logic h, input logic d, input logic [2:0] s, input int p);
        int n, m, k;
        @(posedge mclk);
        host <= h;
        div <= d;
        src <= s;
        pll_ok <= 1'h1;
        dll_ok <= 1'h1;
        por_req <= 1'h1;
        repeat (4) @(posedge mclk);
        por_req <= 1'h0;
        #1;
        chk(hard_oe & soft_oe & ~run, 1'h1);
        waitv(PLLR, 1'h1, 400, n);
        chk({src_q, div_q}, {s, d});
        chk({strap_o, pll_to}, {s, d, 1'h0});
        waitv(DLLR, 1'h1, DMIN + 4, m);
        chk(m >= DMIN - 3 && m < DMIN + 4, 1'h1);
        waitv(HOE, 1'h0, 520 * p, n);
        n = n + m;
        chk(n >= 511 * p && n <= 512 * p + 2, 1'h1);
        waitv(STR, 1'h1, 3 * p + 2, k);
        chk(k >= p && k <= 3 * p + 2, 1'h1);
        waitv(SOE, 1'h0, 17 * p, m);
        chk(k + m, 16 * p);
        chk(run, 1'h1);
        $display("boot host=%0d div=%0d done", h, d);
    endtask

    task automatic t_line(input int p);
        int n;
        @(posedge mclk);
        pull_h <= 1'h1;
        waitv(HOE, 1'h1, 28 * p, n);
        chk(n, 28 * p);
        @(posedge mclk);
        pull_h <= 1'h0;
        repeat (4 * p) @(posedge mclk);
        chk(strap_oe, 1'h1);
        pull_s <= 1'h1;
        waitv(HOE, 1'h1, 34 * p, n);
        chk(n >= 31 * p && n <= 32 * p + 4, 1'h1);
        chk(soft_oe, 1'h1);
        @(posedge mclk);
        pull_s <= 1'h0;
        #1;
        chk(strap_oe, 1'h0);
        waitv(RUN, 1'h1, 560 * p, n);
        chk(run, 1'h1);
        $display("line reset done");
    endtask

    task automatic t_locks(input int p);
        int n;
        @(posedge mclk);
        pll_ok <= 1'h0;
        dll_ok <= 1'h0;
        por_req <= 1'h1;
        repeat (4) @(posedge mclk);
        por_req <= 1'h0;
        waitv(POR, 1'h1, 400, n);
        waitv(PLLT, 1'h1, PLL_SIM + 4, n);
        chk(n >= PLL_SIM - 2 && n <= PLL_SIM + 3 && !pll_rdy, 1'h1);
        waitv(DLLT, 1'h1, DMAX + 4, n);
        chk(n >= DMAX - 3 && n <= DMAX + 3 && !dll_rdy, 1'h1);
        waitv(RUN, 1'h1, 560 * p, n);
        chk(run, 1'h1);
        $display("lock timeouts done");
    endtask

    // Open-drain data must never be high
    always @(posedge mclk) begin
        if (!rst && {hard_o, soft_o} !== 2'h0) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {hard_o, soft_o}, 2'h0);
        end
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            conclude();
        end
    end

    initial begin
        repeat (6) @(posedge mclk);
        #1;
        chk(hard_oe & soft_oe & ~strap_oe & ~run, 1'h1);
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        t_boot(1'h1, 1'h0, 3'h5, 4);
        t_line(4);
        t_boot(1'h1, 1'h1, 3'h2, 8);
        t_boot(1'h0, 1'h1, 3'h7, 6);
        t_locks(6);
        conclude();
    end
endmodule // ris_seq_tb
